// File: epc_pkg.sv
// How it works
// - Fast capture enabled puts its clock on pin three
// - Pins one and two always carry converters
// - One independent converter per pulse pin
// - Phase selects in compensation mode bit groups
// - Select bits 0/1/2 include phases A/B/C
// - Empty phase select adds nothing, no pulses
// - Power types in pulse mode bit groups
// - Type codes pick power; 101-111 reserved
// - Latch request names selected type's energy registers
// - Reset: phase selects ones, types 000/001/010
// - Threshold accumulation, then 16-bit divider stage
// - Divider one gives 1 us low time
// - Divider zero behaves as one
// - Long periods: low for fixed 80 ms
// - Short period, even divider: 50% duty
// - Short period, odd divider: (1+1/N)*50%
// - Peak rate 68.8 kHz at minimum settings
// - Pulse outputs idle high, pulse low
// - Pin disable bits hold pins high, except pin three while fast capture is on
// - Falling converter edge sets status, raises interrupt
// - Latch enable copies energies every N edges
package epc_pkg;

    localparam int NUM_OUT = 3;
    localparam int NUM_PHASE = 3;
    localparam int NUM_TYPE = 5;
    localparam int POWER_W = 24;
    localparam int SEL_W = 3;
    localparam int DEN_W = 16;
    localparam int CYC_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] ADDR_COMP_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_PULSE_MODE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_DIV_ONE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_DIV_TWO = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_DIV_THREE = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_LATCH_CYC = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h1c;
    localparam logic [ADDR_W-1:0] ADDR_THR_ACTIVE = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_THR_REACTIVE = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_THR_APPARENT = 8'h28;
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h2c;
    localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h30;

    localparam int COMP_W = 9;
    localparam int MODE_W = 15;
    localparam int PIN_DIS_LSB = 9;
    localparam int LATCH_EN_LSB = 12;
    localparam int EDGE_IRQ_LSB = 14;

    localparam logic [COMP_W-1:0] COMP_MODE_RST = 9'h1ff;
    localparam logic [MODE_W-1:0] PULSE_MODE_RST = 15'h0e88;
    localparam logic [DEN_W-1:0] DEN_RST = 16'h0000;
    localparam logic [CYC_W-1:0] LATCH_CYC_RST = 8'h01;
    localparam logic [DATA_W-1:0] THR_RST = 32'h0000_0003;
    localparam logic [DATA_W-1:0] SLV_ZERO = 32'h0000_0000;

    localparam int CLK_NS = 50;
    localparam int US_NS = 1000;
    localparam int CYC_PER_US = (US_NS + CLK_NS - 1) / CLK_NS;
    localparam int LOW_MIN_US = 1;
    localparam int LOW_MAX_MS = 80;
    localparam int US_PER_MS = 1000;
    localparam int US_CNT_W = 18;

    typedef enum logic [SEL_W-1:0] {
        PT_TOTAL_ACTIVE = 3'h0,
        PT_TOTAL_REACTIVE = 3'h1,
        PT_APPARENT = 3'h2,
        PT_FUND_ACTIVE = 3'h3,
        PT_FUND_REACTIVE = 3'h4
    } epc_power_kind_type;

    typedef enum logic [1:0] {
        PS_HIGH = 2'b00,
        PS_LOW = 2'b01
    } epc_pulse_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } epc_apb_req_type;

    typedef struct packed {
        logic [NUM_TYPE-1:0][NUM_PHASE-1:0][POWER_W-1:0] p;
    } epc_power_set_type;

endpackage

// File: epc_converter_top.sv
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
module epc_converter_top import epc_pkg::*; #(
    parameter int unsigned LOW_MAX_US = LOW_MAX_MS * US_PER_MS,
    parameter int ACC_W = 48
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // Register bus.
    input wire epc_apb_req_type i_apb,
    output logic o_pready,
    output logic o_pslverr,
    output logic [DATA_W-1:0] o_prdata,
    // Instantaneous phase powers.
    input wire epc_power_set_type i_powers,
    input wire logic i_power_valid,
    // Fast capture clock sharing pin three.
    input wire logic i_fast_capture_clock,
    // Pulse pins and interrupt.
    output logic o_pulse_out_one_n,
    output logic o_pulse_out_two_n,
    output logic o_pulse_out_three_n,
    output logic o_main_interrupt_line,
    // Energy register latch requests.
    output logic [NUM_OUT-1:0] o_latch_strobe,
    output logic [NUM_OUT-1:0][SEL_W-1:0] o_latch_type
);

    function automatic logic signed [ACC_W-1:0] sum_power(
        input epc_power_set_type pw,
        input logic [SEL_W-1:0] kind,
        input logic [NUM_PHASE-1:0] phases
    );
        logic signed [ACC_W-1:0] s;
        s = '0;
        if (kind <= PT_FUND_REACTIVE) begin
            for (int ph = 0; ph < NUM_PHASE; ph++) begin
                if (phases[ph]) begin
                    s = s + ACC_W'($signed(pw.p[kind][ph]));
                end
            end
        end
        return s;
    endfunction

    function automatic logic [DATA_W-1:0] pick_threshold(
        input logic [SEL_W-1:0] kind,
        input logic [DATA_W-1:0] thr_act,
        input logic [DATA_W-1:0] thr_react,
        input logic [DATA_W-1:0] thr_app
    );
        logic [DATA_W-1:0] t;
        case (kind)
            PT_TOTAL_ACTIVE, PT_FUND_ACTIVE: t = thr_act;
            PT_TOTAL_REACTIVE, PT_FUND_REACTIVE: t = thr_react;
            default: t = thr_app;
        endcase
        if (t == SLV_ZERO) begin
            t = DATA_W'(1);
        end
        return t;
    endfunction

    logic [COMP_W-1:0] comp_mode_ff;
    logic [MODE_W-1:0] pulse_mode_ff;
    logic [NUM_OUT-1:0][DEN_W-1:0] pulse_divider_ff;
    logic [CYC_W-1:0] latch_cycle_count_ff;
    logic [NUM_OUT-1:0] irq_mask_ff;
    logic [NUM_OUT-1:0] irq_status_ff;
    logic [DATA_W-1:0] thr_active_ff;
    logic [DATA_W-1:0] thr_reactive_ff;
    logic [DATA_W-1:0] thr_apparent_ff;
    logic fast_capture_en_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic [4:0] us_div_ff;
    logic us_tick_ff;

    logic [NUM_OUT-1:0] conv_low;
    logic [NUM_OUT-1:0] conv_fall;
    logic [NUM_OUT-1:0] latch_fire;

    // Bus decode: one wait state, writes land on the completing access cycle.
    wire access = i_apb.psel & i_apb.penable;
    wire bus_done = access & pready_ff;
    wire wr_en = bus_done & i_apb.pwrite;
    wire hit_comp = i_apb.paddr == ADDR_COMP_MODE;
    wire hit_mode = i_apb.paddr == ADDR_PULSE_MODE;
    wire hit_div1 = i_apb.paddr == ADDR_DIV_ONE;
    wire hit_div2 = i_apb.paddr == ADDR_DIV_TWO;
    wire hit_div3 = i_apb.paddr == ADDR_DIV_THREE;
    wire hit_cyc = i_apb.paddr == ADDR_LATCH_CYC;
    wire hit_mask = i_apb.paddr == ADDR_IRQ_MASK;
    wire hit_stat = i_apb.paddr == ADDR_IRQ_STATUS;
    wire hit_tact = i_apb.paddr == ADDR_THR_ACTIVE;
    wire hit_treact = i_apb.paddr == ADDR_THR_REACTIVE;
    wire hit_tapp = i_apb.paddr == ADDR_THR_APPARENT;
    wire hit_cfg = i_apb.paddr == ADDR_CONFIG;
    wire hit_state = i_apb.paddr == ADDR_STATE;
    wire hit_any = hit_comp | hit_mode | hit_div1 | hit_div2 | hit_div3 | hit_cyc
        | hit_mask | hit_stat | hit_tact | hit_treact | hit_tapp | hit_cfg | hit_state;
    wire hit_ro = hit_state;
    wire [NUM_OUT-1:0] hit_div = {hit_div3, hit_div2, hit_div1};

    logic [DATA_W-1:0] rd_mux;
    assign rd_mux =
        hit_comp ? DATA_W'(comp_mode_ff) :
        hit_mode ? DATA_W'(pulse_mode_ff) :
        hit_div1 ? DATA_W'(pulse_divider_ff[0]) :
        hit_div2 ? DATA_W'(pulse_divider_ff[1]) :
        hit_div3 ? DATA_W'(pulse_divider_ff[2]) :
        hit_cyc ? DATA_W'(latch_cycle_count_ff) :
        hit_mask ? DATA_W'({irq_mask_ff, EDGE_IRQ_LSB'(0)}) :
        hit_stat ? DATA_W'({irq_status_ff, EDGE_IRQ_LSB'(0)}) :
        hit_tact ? thr_active_ff :
        hit_treact ? thr_reactive_ff :
        hit_tapp ? thr_apparent_ff :
        hit_cfg ? DATA_W'(fast_capture_en_ff) :
        hit_state ? DATA_W'(conv_low) : SLV_ZERO;

    wire [NUM_OUT-1:0] stat_clear = (wr_en & hit_stat) ?
        i_apb.pwdata[EDGE_IRQ_LSB +: NUM_OUT] : '0;
    // A converter edge in the clearing cycle wins over the clear.
    wire [NUM_OUT-1:0] nxt_irq_status = (irq_status_ff & ~stat_clear) | conv_fall;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= SLV_ZERO;
        end else begin
            pready_ff <= access & ~pready_ff;
            pslverr_ff <= access & ~pready_ff & (~hit_any | (i_apb.pwrite & hit_ro));
            prdata_ff <= (access & ~pready_ff & ~i_apb.pwrite) ? rd_mux : SLV_ZERO;
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            comp_mode_ff <= COMP_MODE_RST;
            pulse_mode_ff <= PULSE_MODE_RST;
            latch_cycle_count_ff <= LATCH_CYC_RST;
            irq_mask_ff <= '0;
            thr_active_ff <= THR_RST;
            thr_reactive_ff <= THR_RST;
            thr_apparent_ff <= THR_RST;
            fast_capture_en_ff <= 1'b0;
        end else if (wr_en) begin
            if (hit_comp) begin
                comp_mode_ff <= i_apb.pwdata[COMP_W-1:0];
            end
            if (hit_mode) begin
                pulse_mode_ff <= i_apb.pwdata[MODE_W-1:0];
            end
            if (hit_cyc) begin
                latch_cycle_count_ff <= i_apb.pwdata[CYC_W-1:0];
            end
            if (hit_mask) begin
                irq_mask_ff <= i_apb.pwdata[EDGE_IRQ_LSB +: NUM_OUT];
            end
            if (hit_tact) begin
                thr_active_ff <= i_apb.pwdata;
            end
            if (hit_treact) begin
                thr_reactive_ff <= i_apb.pwdata;
            end
            if (hit_tapp) begin
                thr_apparent_ff <= i_apb.pwdata;
            end
            if (hit_cfg) begin
                fast_capture_en_ff <= i_apb.pwdata[0];
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_status_ff <= '0;
        end else begin
            irq_status_ff <= nxt_irq_status;
        end
    end

    // Microsecond enable for the low-time timers.
    wire us_wrap = us_div_ff == 5'(CYC_PER_US - 1);
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            us_div_ff <= '0;
            us_tick_ff <= 1'b0;
        end else begin
            us_div_ff <= us_wrap ? '0 : us_div_ff + 5'd1;
            us_tick_ff <= us_wrap;
        end
    end

    for (genvar g = 0; g < NUM_OUT; g++) begin : g_conv
        logic signed [ACC_W-1:0] acc_ff;
        logic [DEN_W-1:0] div_cnt_ff;
        logic [DEN_W-1:0] low_ticks_ff;
        logic [US_CNT_W-1:0] low_us_ff;
        logic [CYC_W-1:0] latch_cnt_ff;
        epc_pulse_state_type state_ff;
        epc_pulse_state_type nxt_state;

        // Selects are read live so a rewrite leaves the divider running.
        wire [NUM_PHASE-1:0] phases = comp_mode_ff[g*SEL_W +: SEL_W];
        wire [SEL_W-1:0] kind = pulse_mode_ff[g*SEL_W +: SEL_W];
        wire no_phase = phases == '0;
        wire signed [ACC_W-1:0] thr = ACC_W'(pick_threshold(kind, thr_active_ff,
            thr_reactive_ff, thr_apparent_ff));
        wire signed [ACC_W-1:0] step = sum_power(i_powers, kind, phases);
        wire signed [ACC_W-1:0] acc_sum = acc_ff + step;
        wire pos_cross = acc_sum >= thr;
        wire neg_cross = acc_sum <= -thr;
        // First-stage threshold tick feeding the divider.
        wire tick = i_power_valid & ~no_phase & (pos_cross | neg_cross);
        wire [DEN_W-1:0] den = pulse_divider_ff[g];
        wire [DEN_W-1:0] den_eff = (den == '0) ? DEN_W'(1) : den;
        wire [DEN_W-1:0] half = DEN_W'(({1'b0, den_eff} + 17'd1) >> 1);
        wire div_wrap = tick & (div_cnt_ff + DEN_W'(1) >= den_eff);
        wire short_den = den_eff == DEN_W'(1);
        // The closing tick ends the low phase at its own edge, so low spans whole tick gaps.
        wire end_half = ~short_den & ((low_ticks_ff + DEN_W'(tick)) >= half);
        wire end_min = short_den & (low_ticks_ff >= DEN_W'(CYC_PER_US * LOW_MIN_US - 1));
        wire end_max = low_us_ff >= US_CNT_W'(LOW_MAX_US);
        wire cyc_hit = latch_cnt_ff + CYC_W'(1) >= latch_cycle_count_ff;

        always_comb begin
            case (state_ff)
                PS_HIGH: nxt_state = div_wrap ? PS_LOW : PS_HIGH;
                PS_LOW: nxt_state = (~div_wrap & (end_half | end_min | end_max)) ?
                    PS_HIGH : PS_LOW;
                default: nxt_state = PS_HIGH;
            endcase
        end

        assign conv_low[g] = state_ff == PS_LOW;
        assign conv_fall[g] = (state_ff == PS_HIGH) & div_wrap;
        assign latch_fire[g] = conv_fall[g] & pulse_mode_ff[LATCH_EN_LSB + g] & cyc_hit;

        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
                acc_ff <= '0;
            end else if (i_power_valid & ~no_phase) begin
                acc_ff <= pos_cross ? acc_sum - thr : neg_cross ? acc_sum + thr : acc_sum;
            end
        end

        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
                div_cnt_ff <= '0;
            end else if (tick) begin
                div_cnt_ff <= div_wrap ? '0 : div_cnt_ff + DEN_W'(1);
            end
        end

        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
                state_ff <= PS_HIGH;
                low_ticks_ff <= '0;
                low_us_ff <= '0;
            end else begin
                state_ff <= nxt_state;
                if (div_wrap) begin
                    low_ticks_ff <= '0;
                    low_us_ff <= '0;
                end else if (state_ff == PS_LOW) begin
                    // With a divider of one the tick counter times the low phase in cycles.
                    if (tick | short_den) begin
                        low_ticks_ff <= low_ticks_ff + DEN_W'(1);
                    end
                    if (us_tick_ff & ~end_max) begin
                        low_us_ff <= low_us_ff + US_CNT_W'(1);
                    end
                end
            end
        end

        // Counts falling edges between energy register latches.
        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
                latch_cnt_ff <= '0;
            end else if (conv_fall[g] & pulse_mode_ff[LATCH_EN_LSB + g]) begin
                latch_cnt_ff <= cyc_hit ? '0 : latch_cnt_ff + CYC_W'(1);
            end
        end

        always_ff @(posedge i_clk or posedge i_reset) begin
            if (i_reset) begin
                pulse_divider_ff[g] <= DEN_RST;
                o_latch_strobe[g] <= 1'b0;
                o_latch_type[g] <= PT_TOTAL_ACTIVE;
            end else begin
                if (wr_en & hit_div[g]) begin
                    pulse_divider_ff[g] <= i_apb.pwdata[DEN_W-1:0];
                end
                o_latch_strobe[g] <= latch_fire[g];
                if (latch_fire[g]) begin
                    o_latch_type[g] <= kind;
                end
            end
        end
    end

    wire [NUM_OUT-1:0] pin_dis = pulse_mode_ff[PIN_DIS_LSB +: NUM_OUT];
    wire [NUM_OUT-1:0] pin_level = pin_dis | ~conv_low;

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pulse_out_one_n <= 1'b1;
            o_pulse_out_two_n <= 1'b1;
            o_pulse_out_three_n <= 1'b1;
            o_main_interrupt_line <= 1'b0;
        end else begin
            o_pulse_out_one_n <= pin_level[0];
            o_pulse_out_two_n <= pin_level[1];
            o_pulse_out_three_n <= fast_capture_en_ff ? i_fast_capture_clock : pin_level[2];
            o_main_interrupt_line <= |(nxt_irq_status & irq_mask_ff);
        end
    end

    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;
    assign o_prdata = prdata_ff;

endmodule

// File: epc_converter_asserts.sv
`timescale 1ns/1ps
module epc_converter_asserts import epc_pkg::*; #(
    parameter int unsigned LOW_MAX_US = 8
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset,
    // Register bus.
    input wire epc_apb_req_type i_apb,
    input wire logic o_pready,
    // Capture clock, pins and events.
    input wire logic i_fast_capture_clock,
    input wire logic o_pulse_out_one_n,
    input wire logic o_pulse_out_three_n,
    input wire logic o_main_interrupt_line,
    input wire logic [NUM_OUT-1:0] o_latch_strobe,
    input wire logic [NUM_OUT-1:0][SEL_W-1:0] o_latch_type
);
    localparam int LOW_LIM = LOW_MAX_US * CYC_PER_US + 2 * CYC_PER_US;
    // Shadow copies of the registers, indexed by word address.
    logic [DATA_W-1:0] shd_ff [13];
    logic [2:0] zsel_ff;
    int low_ff;
    logic wr_ok;
    assign wr_ok = i_apb.psel & i_apb.penable & i_apb.pwrite & o_pready;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            shd_ff <= '{0: 32'(COMP_MODE_RST), 1: 32'(PULSE_MODE_RST), default: 32'h0};
        end else if (wr_ok && i_apb.paddr < 8'h34) begin
            shd_ff[i_apb.paddr[5:2]] <= i_apb.pwdata;
        end
    end
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            zsel_ff <= 3'h0;
            low_ff <= 0;
        end else begin
            zsel_ff <= (shd_ff[0][2:0] != 3'h0) ? 3'h0 : zsel_ff + {2'h0, zsel_ff != 3'h7};
            low_ff <= o_pulse_out_one_n ? 0 : low_ff + 1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    chk_idle_reset: assert property ($fell(i_reset) |-> o_pulse_out_one_n)
        else $error("pin one not idle high after reset");
    chk_fast_clock: assert property (shd_ff[11][0] && $past(shd_ff[11][0])
        |-> o_pulse_out_three_n == $past(i_fast_capture_clock))
        else $error("pin three does not carry the capture clock");
    chk_latch_kind: assert property (o_latch_strobe[0] |-> o_latch_type[0] == shd_ff[1][2:0])
        else $error("latch type differs from selected power");
    chk_pin_disable: assert property (shd_ff[1][9] && $past(shd_ff[1][9]) |-> o_pulse_out_one_n)
        else $error("disabled pin one driven low");
    chk_edge_irq: assert property ($fell(o_pulse_out_one_n) && shd_ff[6][14]
        |-> ##[0:1] o_main_interrupt_line)
        else $error("falling pulse did not raise interrupt");
    chk_empty_select: assert property (zsel_ff == 3'h7 |-> !$fell(o_pulse_out_one_n))
        else $error("pulse with empty phase select");
    chk_short_low: assert property ($rose(o_pulse_out_one_n) && shd_ff[2] <= 32'h1
        && !shd_ff[1][9] |-> low_ff inside {[19:41]})
        else $error("low time wrong for divider zero or one");
    chk_low_ceiling: assert property (!o_pulse_out_one_n |-> low_ff < LOW_LIM)
        else $error("pulse low beyond ceiling");
endmodule
bind epc_converter_top epc_converter_asserts #(.LOW_MAX_US(LOW_MAX_US)) u_chk (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_apb(i_apb),
    .o_pready(o_pready),
    .i_fast_capture_clock(i_fast_capture_clock),
    .o_pulse_out_one_n(o_pulse_out_one_n),
    .o_pulse_out_three_n(o_pulse_out_three_n),
    .o_main_interrupt_line(o_main_interrupt_line),
    .o_latch_strobe(o_latch_strobe),
    .o_latch_type(o_latch_type)
);

// File: epc_optical_probe.sv
`timescale 1ns/1ps
module epc_optical_probe (
    // Clock and count clear.
    input wire logic i_clk,
    input wire logic i_clr,
    // Light pins, lit while low.
    input wire logic [2:0] i_led_n,
    // Flash counts and last lit width in cycles.
    output int o_flashes [3],
    output int o_lit [3]
);
    logic [2:0] prev_ff = 3'h7;
    int run_ff [3];
    always @(posedge i_clk) begin
        prev_ff <= i_led_n;
        for (int k = 0; k < 3; k++) begin
            if (i_clr) o_flashes[k] <= 0;
            else if (prev_ff[k] && !i_led_n[k]) o_flashes[k] <= o_flashes[k] + 1;
            if (!i_led_n[k]) begin
                run_ff[k] <= run_ff[k] + 1;
            end else begin
                if (!prev_ff[k]) o_lit[k] <= run_ff[k];
                run_ff[k] <= 0;
            end
        end
    end
endmodule

// File: energy_to_pulse_converter_tb.sv
`timescale 1ns/1ps
module energy_to_pulse_converter_tb import epc_pkg::*; ();
    localparam int LMAX = 8;
    localparam int GAP = 50;
    localparam int LIMIT = 20000;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic pv = 1'b0;
    logic fcc = 1'b0;
    logic clr = 1'b0;
    epc_apb_req_type apb = '0;
    epc_power_set_type pw = '0;
    logic rdy, err, irq, p1, p2, p3, e;
    logic [DATA_W-1:0] prd, rd;
    logic [NUM_OUT-1:0] stb;
    logic [NUM_OUT-1:0][SEL_W-1:0] typ;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    int nstb = 0;
    int fl [3];
    int lit [3];
    epc_converter_top #(.LOW_MAX_US(LMAX)) uut (
        .i_clk(i_clk), .i_reset(i_reset), .i_apb(apb), .o_pready(rdy),
        .o_pslverr(err), .o_prdata(prd), .i_powers(pw), .i_power_valid(pv),
        .i_fast_capture_clock(fcc), .o_pulse_out_one_n(p1), .o_pulse_out_two_n(p2),
        .o_pulse_out_three_n(p3), .o_main_interrupt_line(irq),
        .o_latch_strobe(stb), .o_latch_type(typ));
    epc_optical_probe probe (.i_clk(i_clk), .i_clr(clr), .i_led_n({p3, p2, p1}),
        .o_flashes(fl), .o_lit(lit));
    always #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc++;
        if (stb[0] === 1'b1) nstb++;
        if (cyc == LIMIT) begin
            fail("timeout");
            summarize();
        end
    end
    task summarize;
        $display("Counts: %0d compares, %0d mismatches", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task fail(input string m);
        error_cnt++;
        $display("Error at %0t: %s", $time, m);
    endtask
    task chk_word(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] x);
        n_tests++;
        if (g !== x) fail($sformatf("word %h, expected %h", g, x));
    endtask
    task chk_bit(input logic g, input logic x);
        n_tests++;
        if (g !== x) fail($sformatf("bit %b, expected %b", g, x));
    endtask
    task chk_int(input int g, input int lo, input int hi);
        n_tests++;
        if (g < lo || g > hi) fail($sformatf("count %0d not in %0d..%0d", g, lo, hi));
    endtask
    task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_clk);
        apb <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_clk);
        apb.penable <= 1'b1;
        @(posedge i_clk);
        while (rdy !== 1'b1) @(posedge i_clk);
        rd = prd;
        e = err;
        apb <= '0;
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        bus(1'b1, a, d);
    endtask
    task rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] x);
        bus(1'b0, a, 32'h0);
        chk_word(rd, x);
        chk_bit(e, 1'b0);
    endtask
    task power(input int t, input logic [NUM_PHASE-1:0] ph);
        @(posedge i_clk);
        for (int k = 0; k < NUM_PHASE; k++) pw.p[t][k] <= ph[k] ? 24'h000003 : 24'h000000;
    endtask
    // Clears the probe's flash counts, then sends n samples that each cross the threshold once.
    task flash(input int n);
        @(posedge i_clk);
        clr <= 1'b1;
        @(posedge i_clk);
        clr <= 1'b0;
        repeat (n) begin
            @(posedge i_clk);
            pv <= 1'b1;
            @(posedge i_clk);
            pv <= 1'b0;
            repeat (GAP - 2) @(posedge i_clk);
        end
        repeat (GAP) @(posedge i_clk);
    endtask
    initial begin
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        rdc(ADDR_COMP_MODE, 32'h0000_01ff);
        rdc(ADDR_PULSE_MODE, 32'h0000_0e88);
        bus(1'b0, 8'h40, 32'h0);
        chk_bit(e, 1'b1);
        power(0, 3'b001);
        power(1, 3'b010);
        power(2, 3'b100);
        flash(2);
        chk_int(fl[0] + fl[1] + fl[2], 0, 0);
        rdc(ADDR_IRQ_STATUS, 32'h0001_c000);
        $display("Test reset values done");
        wr(ADDR_DIV_ONE, 32'h0);
        wr(ADDR_DIV_TWO, 32'h3);
        wr(ADDR_DIV_THREE, 32'h2);
        wr(ADDR_PULSE_MODE, 32'h0000_0088);
        rdc(ADDR_DIV_TWO, 32'h3);
        flash(12);
        chk_int(fl[0], 12, 12);
        chk_int(fl[1], 4, 4);
        chk_int(fl[2], 6, 6);
        chk_int(lit[0], CYC_PER_US, 2 * CYC_PER_US);
        chk_int(lit[1], 2 * GAP, 2 * GAP);
        chk_int(lit[2], GAP, GAP);
        $display("Test dividers done");
        for (int p = 0; p < 3; p++) begin
            power(0, 3'b001 << p);
            wr(ADDR_COMP_MODE, 32'h1f8 | (32'h1 << p));
            flash(2);
            chk_int(fl[0], 2, 2);
            wr(ADDR_COMP_MODE, 32'h1f8 | (32'h1 << ((p + 1) % 3)));
            flash(2);
            chk_int(fl[0], 0, 0);
        end
        power(0, 3'b111);
        wr(ADDR_COMP_MODE, 32'h1f8);
        flash(2);
        chk_int(fl[0], 0, 0);
        $display("Test phase selects done");
        wr(ADDR_COMP_MODE, 32'h1f9);
        for (int t = 0; t < 8; t++) begin
            for (int k = 0; k < NUM_TYPE; k++) power(k, (k == t || t > 4) ? 3'b001 : 3'b000);
            wr(ADDR_PULSE_MODE, 32'h88 | t);
            flash(2);
            chk_int(fl[0], (t < NUM_TYPE) ? 2 : 0, (t < NUM_TYPE) ? 2 : 0);
        end
        $display("Test power types done");
        wr(ADDR_PULSE_MODE, 32'h0000_0088);
        wr(ADDR_DIV_ONE, 32'h8);
        flash(16);
        repeat (4 * GAP) @(posedge i_clk);
        chk_int(fl[0], 2, 2);
        chk_int(lit[0], (LMAX - 1) * CYC_PER_US, (LMAX + 1) * CYC_PER_US);
        $display("Test long period done");
        wr(ADDR_DIV_ONE, 32'h2);
        wr(ADDR_IRQ_STATUS, 32'h0001_c000);
        rdc(ADDR_IRQ_STATUS, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h0000_4000);
        wr(ADDR_LATCH_CYC, 32'h2);
        wr(ADDR_PULSE_MODE, 32'h0000_1088);
        nstb = 0;
        flash(8);
        chk_int(nstb, 2, 2);
        chk_word(32'(typ[0]), 32'h0);
        chk_bit(irq, 1'b1);
        wr(ADDR_IRQ_STATUS, 32'h0001_c000);
        repeat (2) @(posedge i_clk);
        chk_bit(irq, 1'b0);
        $display("Test interrupt and latch done");
        wr(ADDR_CONFIG, 32'h1);
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            fcc <= k[0];
            repeat (3) @(posedge i_clk);
            chk_bit(p3, k[0]);
        end
        flash(4);
        chk_int(fl[0], 2, 2);
        $display("Test fast capture done");
        summarize();
    end
endmodule
